/* File: spl_host.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// programming host model on the far side of the byte link
// ------------------------------------------------------------------
module spl_host import spl_pkg::*; (
  input wire logic mclk,
  output logic rx_valid,
  output logic [BYTE_W-1:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [BYTE_W-1:0] tx_data,
  output logic tx_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    tx_ready = 1'b0;
  end

  // the caller gives the guard time; the host never sends sooner
  task automatic send(input logic [7:0] b, input int guard,
                      output logic ok);
    int n;
    repeat (guard) @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rx_ready !== 1'b1 && n < 5000);
    ok = (rx_ready === 1'b1);
    rx_valid <= 1'b0;
    // released line shows the inverse, never the stale byte
    rx_data <= ~b;
  endtask

  // lat counts edges from the push edge to the first sampled echo
  task automatic echo(input int stall, output logic [7:0] b,
                      output int lat);
    lat = 0;
    while (tx_valid !== 1'b1 && lat < 3000) begin
      @(posedge mclk);
      lat++;
    end
    repeat (stall) @(posedge mclk);
    tx_ready <= 1'b1;
    @(posedge mclk);
    b = (tx_valid === 1'b1) ? tx_data : 'x;
    tx_ready <= 1'b0;
  endtask
endmodule

/* File: spl_loader.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// byte fifo
// ------------------------------------------------------------------
module spl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Notes on behaviour
// R1 - prom mode, gate clear: non-loader inputs fixed
// R2 - gate bit: 0 inputs invalid, 1 valid
// R3 - gate writes ignored outside prom mode
// R4 - mcu-mode gate read: upper bits undefined
// R5 - ram loader code sets gate bit first
// R6 - match byte echoed after 930 cycles
// R7 - baud byte echoed after 980 cycles
// R8 - command byte echoed after 800 cycles
// R9 - full erase busy for 30 ms
// R10 - sector erase 15 ms, 4-kbyte sectors
// R11 - no start bit accepted before 2100 cycles
// R12 - host waits 380 cycles before baud byte
// R13 - host waits 650 cycles before command
// R14 - host waits 800 cycles before address
// R15 - erase of non-flash sector halts link
module spl_loader import spl_pkg::*; #(
  parameter int unsigned FULL_ERASE_LEN = FULL_ERASE_CYC,
  parameter int unsigned SECTOR_ERASE_LEN = SECTOR_ERASE_CYC,
  parameter logic [3:0] FIRST_SECTOR = FIRST_SECTOR_DEF
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prom_mode,
  input wire logic [PORT_W-1:0] port_pins,
  output logic [PORT_W-1:0] port_in_gated,
  input wire logic rx_valid,
  input wire logic [BYTE_W-1:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [BYTE_W-1:0] tx_data,
  input wire logic tx_ready
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [PORT_W:0] pin_meta;
  logic [PORT_W:0] pin_sync;
  wire prom_s = pin_sync[PORT_W];
  wire [PORT_W-1:0] pins_s = pin_sync[PORT_W-1:0];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {prom_mode, port_pins};
      pin_sync <= pin_meta;
    end
  end

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_gate = (paddr == ADDR_GATE);
  wire hit_erase = (paddr == ADDR_ERASE);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_rxdata = (paddr == ADDR_RXDATA);
  wire hit_any = hit_gate || hit_erase || hit_status || hit_rxdata;

  // ------------------------------------------------------------------
  // port input gate
  // ------------------------------------------------------------------
  logic gate_valid;
  // mcu mode never touches the gate, so a stray write cannot unlock pins
  wire gate_wr = wr && hit_gate && prom_s; // R3
  wire pins_frozen = prom_s && !gate_valid; // R2
  // frozen inputs read low; loader pins always pass
  wire [PORT_W-1:0] next_gated =
    pins_frozen ? (pins_s & LOADER_MASK) : pins_s; // R1

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate_valid <= GATE_RESET;
      port_in_gated <= '0;
    end else begin
      gate_valid <= gate_wr ? pwdata[GATE_VALID_BIT] : gate_valid; // R2
      port_in_gated <= next_gated;
    end
  end

  // ------------------------------------------------------------------
  // receive fifo and sequencer
  // ------------------------------------------------------------------
  spl_state_t state;
  spl_state_t next_state;
  spl_phase_t phase;
  logic [DLY_W-1:0] dly_cnt;
  logic [DLY_W-1:0] boot_cnt;
  logic [BYTE_W-1:0] echo_byte;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [BYTE_W-1:0] fifo_out_data;
  logic erase_busy;

  wire link_open = (state != ST_BOOT) && (state != ST_HALT);
  assign rx_ready = fifo_in_ready && link_open; // R11 R15
  wire seq_pop = (state == ST_IDLE) && (phase != PH_DATA) && fifo_out_valid;
  wire rd_pop = rd && hit_rxdata && (phase == PH_DATA) && fifo_out_valid;
  assign tx_valid = (state == ST_ECHO);
  assign tx_data = echo_byte;

  spl_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(rx_valid && link_open),
    .in_data(rx_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(seq_pop || rd_pop)
  );

  // each echo is its own delay, so the host sees the loader's think time
  wire [DLY_W-1:0] echo_len =
    (phase == PH_MATCH) ? DLY_W'(MATCH_ECHO_CYC - 1) : // R6
    (phase == PH_BAUD) ? DLY_W'(BAUD_ECHO_CYC - 1) : // R7
    DLY_W'(CMD_ECHO_CYC - 1); // R8

  // ------------------------------------------------------------------
  // erase timer
  // ------------------------------------------------------------------
  logic [ERASE_W-1:0] erase_cnt;
  logic erase_full;
  wire erase_go = wr && hit_erase && pwdata[ERASE_GO_BIT] && !erase_busy
    && link_open;
  wire go_full = pwdata[ERASE_FULL_BIT];
  wire [3:0] go_sector = pwdata[ERASE_SECT_LSB +: 4];
  wire bad_sector = erase_go && !go_full && (go_sector < FIRST_SECTOR);
  wire [ERASE_W-1:0] erase_len = go_full ?
    ERASE_W'(FULL_ERASE_LEN - 1) : ERASE_W'(SECTOR_ERASE_LEN - 1); // R9 R10

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      erase_busy <= 1'b0;
      erase_cnt <= '0;
      erase_full <= 1'b0;
    end else if (erase_go && !bad_sector) begin
      erase_busy <= 1'b1;
      erase_cnt <= erase_len; // R9 R10
      erase_full <= go_full;
    end else if (erase_busy) begin
      erase_busy <= (erase_cnt != '0);
      erase_cnt <= erase_cnt - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_BOOT: begin
        if (boot_cnt == DLY_W'(BOOT_RX_CYC - 1)) begin
          next_state = ST_IDLE; // R11
        end
      end
      ST_IDLE: begin
        if (seq_pop) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_cnt == '0) begin
          next_state = ST_ECHO;
        end
      end
      ST_ECHO: begin
        if (tx_ready) begin
          next_state = ST_IDLE;
        end
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
    // a bad erase target wins over everything and never recovers
    if (bad_sector) begin
      next_state = ST_HALT; // R15
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_BOOT;
      boot_cnt <= '0;
    end else begin
      state <= next_state;
      boot_cnt <= (state == ST_BOOT) ? boot_cnt + 1'b1 : boot_cnt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PH_MATCH;
      dly_cnt <= '0;
      echo_byte <= '0;
    end else if (seq_pop) begin
      dly_cnt <= echo_len;
      echo_byte <= fifo_out_data;
    end else if (state == ST_DELAY) begin
      dly_cnt <= dly_cnt - 1'b1;
    end else if ((state == ST_ECHO) && tx_ready) begin
      phase <= spl_phase_t'(phase + 2'h1);
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  // upper gate bits are undefined in mcu mode; they simply read low
  wire [31:0] rd_gate = {31'h0, gate_valid}; // R4
  wire [31:0] rd_status = {25'h0, prom_s, phase, fifo_out_valid,
    state == ST_HALT, erase_busy, state == ST_BOOT};
  wire [31:0] rd_rx = {24'h0, fifo_out_valid ? fifo_out_data : 8'h00};
  wire [31:0] rd_erase = {30'h0, erase_full, erase_busy};

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata = !rd ? 32'h0 : hit_gate ? rd_gate :
    hit_erase ? rd_erase : hit_status ? rd_status :
    hit_rxdata ? rd_rx : 32'h0;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [DLY_W-1:0] dly_seen;
  logic [ERASE_W-1:0] erase_seen;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dly_seen <= '0;
      erase_seen <= '0;
    end else begin
      dly_seen <= seq_pop ? '0 :
        (state == ST_DELAY) ? dly_seen + 1'b1 : dly_seen;
      erase_seen <= (erase_go && !bad_sector) ? '0 :
        erase_busy ? erase_seen + 1'b1 : erase_seen;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence bad_target_s;
    bad_sector;
  endsequence
  sequence link_dead_s;
    (!rx_ready && !tx_valid && state == ST_HALT) [*4];
  endsequence

  AST_PINS_FROZEN: assert property ( // R1
    pins_frozen |=> ((port_in_gated & ~LOADER_MASK) == 8'h00))
    else $error("non-loader port input passed while frozen");
  AST_PINS_OPEN: assert property ( // R2
    (prom_s && gate_valid && $stable(pins_s)) |=>
      port_in_gated == $past(pins_s))
    else $error("port input blocked while gate set");
  AST_GATE_WRITE: assert property ( // R2
    (wr && hit_gate && prom_s) |=> gate_valid == $past(pwdata[0]))
    else $error("gate write not stored");
  AST_MCU_NO_WRITE: assert property ( // R3
    (wr && hit_gate && !prom_s) |=> $stable(gate_valid))
    else $error("gate changed by mcu-mode write");
  AST_GATE_READ: assert property ( // R4
    (rd && hit_gate) |-> prdata == {31'h0, gate_valid})
    else $error("gate read value wrong");
  AST_MATCH_ECHO: assert property ( // R6
    ($rose(tx_valid) && phase == PH_MATCH) |-> dly_seen == 12'h3A2)
    else $error("match echo delay wrong");
  AST_BAUD_ECHO: assert property ( // R7
    ($rose(tx_valid) && phase == PH_BAUD) |-> dly_seen == 12'h3D4)
    else $error("baud echo delay wrong");
  AST_CMD_ECHO: assert property ( // R8
    ($rose(tx_valid) && phase == PH_CMD) |-> dly_seen == 12'h320)
    else $error("command echo delay wrong");
  AST_ERASE_LEN: assert property ( // R9 R10
    $fell(erase_busy) |-> erase_seen == (erase_full ?
      ERASE_W'(FULL_ERASE_LEN) : ERASE_W'(SECTOR_ERASE_LEN)))
    else $error("erase busy length wrong");
  AST_BOOT_CLOSED: assert property ( // R11
    (state == ST_BOOT) |-> (!rx_ready && boot_cnt < 12'h834))
    else $error("receive open during boot wait");
  AST_BAD_HALT: assert property ( // R15
    bad_target_s |=> link_dead_s)
    else $error("link not halted after bad erase target");

endmodule

/* File: spl_pkg.sv */
package spl_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned US_PER_MS = 1000;
  // echo and guard times, counted in main oscillator cycles
  localparam int unsigned MATCH_ECHO_CYC = 930;
  localparam int unsigned BAUD_ECHO_CYC = 980;
  localparam int unsigned CMD_ECHO_CYC = 800;
  localparam int unsigned BOOT_RX_CYC = 2100;
  // erase times in milliseconds, independent of the clock rate
  localparam int unsigned FULL_ERASE_MS = 30;
  localparam int unsigned SECTOR_ERASE_MS = 15;
  localparam int unsigned FULL_ERASE_CYC = FULL_ERASE_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned SECTOR_ERASE_CYC =
    SECTOR_ERASE_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned SECTOR_BYTES = 4096;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned PORT_W = 8;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned DLY_W = 12;
  localparam int unsigned ERASE_W = 22;
  localparam int unsigned ADDR_W = 8;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_GATE = 8'h00;
  localparam logic [7:0] ADDR_ERASE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam int unsigned GATE_VALID_BIT = 0;
  localparam logic GATE_RESET = 1'b0;
  localparam int unsigned ERASE_GO_BIT = 0;
  localparam int unsigned ERASE_FULL_BIT = 1;
  localparam int unsigned ERASE_SECT_LSB = 12;
  localparam int unsigned ST_BOOT_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_HALT_BIT = 2;
  localparam int unsigned ST_AVAIL_BIT = 3;
  localparam int unsigned ST_PHASE_LSB = 4;
  localparam int unsigned ST_PROM_BIT = 6;
  localparam logic [3:0] FIRST_SECTOR_DEF = 4'hC;

  // ------------------------------------------------------------------
  // loader pins and types
  // ------------------------------------------------------------------
  localparam int unsigned LOADER_PIN_A = 3;
  localparam int unsigned LOADER_PIN_B = 2;
  localparam logic [7:0] LOADER_MASK = 8'h0C;

  typedef enum logic [4:0] {
    ST_BOOT = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_ECHO = 5'b01000,
    ST_HALT = 5'b10000
  } spl_state_t;

  typedef enum logic [1:0] {
    PH_MATCH = 2'h0,
    PH_BAUD = 2'h1,
    PH_CMD = 2'h2,
    PH_DATA = 2'h3
  } spl_phase_t;

endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top import spl_pkg::*; ;
  localparam int FL = 40;
  localparam int SL = 20;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, prom_mode;
  logic rx_valid, rx_ready, tx_valid, tx_ready, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [PORT_W-1:0] port_pins, port_in_gated;
  logic [BYTE_W-1:0] rx_data, tx_data;
  int err_count = 0;
  int checks_done = 0;

  spl_loader #(.FULL_ERASE_LEN(FL), .SECTOR_ERASE_LEN(SL)) uut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prom_mode(prom_mode),
    .port_pins(port_pins), .port_in_gated(port_in_gated),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  spl_host host (
    .mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  // ------------------------------------------------------------------
  // report and compare
  // ------------------------------------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_n(input int g, input int e, input string m);
    checks_done++;
    if (g != e) begin
      err_count++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask

  // ------------------------------------------------------------------
  // bus and link tasks
  // ------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic push(input logic [7:0] b, input int g);
    logic ok;
    host.send(b, g, ok);
    chk(32'(ok), 32'h1, "byte refused");
    if (ok !== 1'b1) end_of_test();
  endtask

  task automatic echo(input int st, input logic [7:0] b, input int n);
    logic [7:0] got;
    int lat;
    host.echo(st, got, lat);
    chk_n(lat, n + 2, "echo delay");
    chk(32'(got), 32'(b), "echo byte");
    if (lat >= 3000) end_of_test();
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    prom_mode = 1'b0;
    port_pins = 8'hFF;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (BOOT_RX_CYC) @(posedge mclk);
    chk(32'(rx_ready), 32'h0, "ready early");
    @(posedge mclk);
    chk(32'(rx_ready), 32'h1, "ready late");
    apb(1'b0, ADDR_GATE, 32'h0);
    chk(d, 32'h0, "gate mcu read");
    apb(1'b1, ADDR_GATE, 32'h1);
    prom_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, ADDR_GATE, 32'h0);
    chk(d, 32'h0, "mcu write landed");
    chk(32'(port_in_gated), 32'(LOADER_MASK), "inputs not frozen");
    apb(1'b1, ADDR_GATE, 32'h1);
    port_pins <= 8'h5A;
    repeat (4) @(posedge mclk);
    apb(1'b0, ADDR_GATE, 32'h0);
    chk(d, 32'h1, "gate set");
    chk(32'(er), 32'h0, "mapped error");
    chk(32'(port_in_gated), 32'h5A, "inputs not valid");
    apb(1'b0, 8'h10, 32'h0);
    chk(d, 32'h0, "unmapped data");
    chk(32'(er), 32'h1, "unmapped error");
    push(8'h86, 0);
    echo(0, 8'h86, MATCH_ECHO_CYC);
    push(8'h07, 380);
    echo(5, 8'h07, BAUD_ECHO_CYC);
    push(8'h0A, 650);
    echo(0, 8'h0A, CMD_ECHO_CYC);
    push(8'h30, 800);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(d[ST_PROM_BIT:0]), 32'h78, "status");
    // data bytes are not echoed, so the fifo fills while software waits
    for (int i = 1; i < FIFO_DEPTH; i++) push(8'h30 + 8'(i), 1);
    @(posedge mclk);
    chk(32'(rx_ready), 32'h0, "fifo full");
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      apb(1'b0, ADDR_RXDATA, 32'h0);
      chk(d, (i < FIFO_DEPTH) ? 32'h30 + 32'(i) : 32'h0, "drain");
    end
    // one read in the last busy cycle and one in the first idle cycle, per erase kind
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_ERASE, {16'h0, 4'hF, 10'h0, k[0], 1'b1});
      repeat ((k[0] ? FL : SL) - 3 + k[1]) @(posedge mclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(d[ST_BUSY_BIT]), 32'(!k[1]), "busy span");
      repeat (FL) @(posedge mclk);
      apb(1'b0, ADDR_ERASE, 32'h0);
      chk(d, {30'h0, k[0], 1'b0}, "erase kind");
    end
    apb(1'b1, ADDR_ERASE, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(d[ST_HALT_BIT]), 32'h1, "halt flag");
    chk(32'({rx_ready, tx_valid}), 32'h0, "link alive");
    end_of_test();
  end
endmodule
